// ==== logic/fpec_pkg.sv ====
// Package with register map, field layout and address constants.
package fpec_pkg;
  localparam logic [15:0] CTRL_ADDR = 16'hFE08;
  localparam logic [15:0] PROT_ADDR = 16'hFFCF;
  localparam logic [15:0] USER_BASE = 16'h9000;
  localparam logic [15:0] USER_TOP = 16'hEFFF;
  localparam logic [15:0] VEC_BASE = 16'hFFD0;
  localparam logic [15:0] VEC_TOP = 16'hFFFF;
  localparam int USER_BYTES = 24576;
  localparam int VEC_BYTES = 48;
  localparam int PAGE_BYTES = 128;
  localparam int ROW_BYTES = 64;
  localparam int BIT_PGM = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_MASS = 2;
  localparam int BIT_HIGH_VOLTAGE_ENABLE = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  localparam logic [1:0] PROT_HI_BITS = 2'h3;
  localparam logic [6:0] PROT_LO_BITS = 7'h00;
  typedef enum logic [4:0] {
    SEQ_IDLE = 5'h01,
    SEQ_SELECTED = 5'h02,
    SEQ_PROT_READ = 5'h04,
    SEQ_LATCHED = 5'h08,
    SEQ_HIGH_V = 5'h10
  } fpec_seq_t;
endpackage : fpec_pkg

// ==== logic/fpec_if.sv ====
// Interface between the sequencer and the flash array storage.
`timescale 1ns/100ps
`default_nettype none
interface fpec_if;
  logic wrEn;
  logic [15:0] wrAddr;
  logic [7:0] wrData;
  logic pageErase;
  logic massErase;
  logic rdEn;
  logic [15:0] rdAddr;
  logic [7:0] rdData;
  modport ctrl (output wrEn, wrAddr, wrData, pageErase, massErase, rdEn,
    rdAddr, input rdData);
  modport mem (input wrEn, wrAddr, wrData, pageErase, massErase, rdEn,
    rdAddr, output rdData);
endinterface : fpec_if
`default_nettype wire

// ==== logic/fpec_array.sv ====
// Flash array storage: user bytes plus vector bytes, registered read.
`timescale 1ns/100ps
`default_nettype none
module fpec_array (
  input wire logic core_clk, // System clock.
  fpec_if.mem bus // Array port.
);
  import fpec_pkg::*;
  // The last cell holds the protect byte, which lives in the array too.
  localparam int DEPTH = USER_BYTES + VEC_BYTES + 1;
  localparam int PROT_IDX = USER_BYTES + VEC_BYTES;
  // Cells start blank, as a part leaves the factory erased.
  logic [7:0] memArr [DEPTH] = '{default: BLANK_BYTE};
  logic [7:0] rdData_ff;
  logic [14:0] wrIdx;
  logic [14:0] rdIdx;
  logic wrVec;
  logic rdVec;

  // Vector bytes sit just above the user bytes in the storage.
  assign wrVec = bus.wrAddr >= VEC_BASE;
  assign rdVec = bus.rdAddr >= VEC_BASE;
  assign wrIdx = (bus.wrAddr == PROT_ADDR) ? 15'(PROT_IDX)
    : wrVec ? 15'(bus.wrAddr - VEC_BASE + 16'(USER_BYTES))
    : 15'(bus.wrAddr - USER_BASE);
  assign rdIdx = (bus.rdAddr == PROT_ADDR) ? 15'(PROT_IDX)
    : rdVec ? 15'(bus.rdAddr - VEC_BASE + 16'(USER_BYTES))
    : 15'(bus.rdAddr - USER_BASE);

  // Programming can only pull bits to zero; erase returns them to one.
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (bus.massErase) begin
        memArr[i] <= BLANK_BYTE;
      end else if (bus.pageErase && i < USER_BYTES &&
        (i / PAGE_BYTES) == (int'(wrIdx) / PAGE_BYTES)) begin
        memArr[i] <= BLANK_BYTE;
      end else if (bus.wrEn && i == int'(wrIdx)) begin
        memArr[i] <= memArr[i] & bus.wrData;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (bus.rdEn) begin
      rdData_ff <= memArr[rdIdx];
    end
  end
  assign bus.rdData = rdData_ff;
endmodule : fpec_array
`default_nettype wire

// ==== logic/fpec_ctrl.sv ====
// Flash program and erase control with register port and protection.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - One control register drives all operations.
// - High voltage set only after proper sequence.
// - High voltage bit drives pump and array.
// - Mass bit picks whole array or page.
// - Program and erase never both set.
// - Select bits configure array for operation.
// - Upper nibble reads zero, reset clears all.
// - Erased bits read one, programmed zero.
// - Page erase clears 128 bytes.
// - 24,576 contiguous user bytes.
// - 48 vector bytes at top.
// - Protect byte in array, programmed only.
// - Security blocks reading array contents; array reads in SEQ_PROT_READ still pass.
// - Protected region refuses high voltage.
// - Protect start from byte bits 14..7.
module fpec_ctrl (
  input wire logic core_clk, // System clock, 20 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic [15:0] addr, // Byte address of the access.
  input wire logic [7:0] wrData, // Write data.
  input wire logic wrStb, // Write strobe.
  input wire logic rdStb, // Read strobe.
  input wire logic secureLock, // Security engaged; hides array except reads in SEQ_PROT_READ.
  output logic [7:0] rdData, // Read data, one cycle after strobe.
  output logic pumpOn, // Charge pump enable.
  output logic highVoltage // High voltage applied to array.
);
  import fpec_pkg::*;
  fpec_if arr ();
  fpec_array uArray (.core_clk(core_clk), .bus(arr));

  logic [3:0] ctrl_ff;
  fpec_seq_t seq_ff;
  logic [15:0] latchAddr_ff;
  logic [7:0] rdData_ff;
  logic rdArr_ff;
  logic rdCtrl_ff;
  logic [7:0] protByte;
  logic [15:0] protStart;
  logic protOn;
  logic inUser;
  logic inVec;
  logic inProt;
  logic inArr;
  logic regionProt;
  logic ctrlWr;
  logic [3:0] nxt_ctrl;
  logic hvReq;
  logic hvOk;
  logic protRd;

  wire program_select = ctrl_ff[BIT_PGM];
  wire eraseSel = ctrl_ff[BIT_ERASE];
  wire massSel = ctrl_ff[BIT_MASS];
  wire high_voltage_enable = ctrl_ff[BIT_HIGH_VOLTAGE_ENABLE];

  assign inUser = addr >= USER_BASE && addr <= USER_TOP;
  assign inVec = addr >= VEC_BASE;
  assign inProt = addr == PROT_ADDR;
  assign inArr = inUser || inVec || inProt;
  assign ctrlWr = wrStb && addr == CTRL_ADDR;
  assign protRd = rdStb && addr == PROT_ADDR;

  // The protect byte lives in the array itself, just below the vector area.
  assign protByte = arr.rdData;
  logic [7:0] protByte_ff;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      protByte_ff <= BLANK_BYTE;
    end else if (rdCtrl_ff == 1'b0 && rdArr_ff && seq_ff == SEQ_PROT_READ) begin
      protByte_ff <= protByte;
    end
  end
  // Start address: ones above, byte in 14..7, zeros below.
  // Bit 14 is the byte's top bit, so a byte of 8'h20 starts at the user base.
  assign protStart = {PROT_HI_BITS[1], protByte_ff, PROT_LO_BITS};
  assign protOn = protByte_ff >= 8'h20 && protByte_ff <= 8'hDF;
  // Vectors are guarded from page erase and from programming, except by a latch at PROT_ADDR while the protect byte is blank.
  // Once programmed, the protect byte guards itself until a mass erase.
  assign regionProt = (latchAddr_ff >= VEC_BASE) ||
    (latchAddr_ff == PROT_ADDR && protByte_ff != BLANK_BYTE) ||
    (protOn && latchAddr_ff >= protStart);

  // Mass erase is allowed over the vectors unless the user area is guarded.
  assign hvOk = (seq_ff == SEQ_LATCHED) && (massSel && eraseSel ?
    !(protOn) : !regionProt);
  assign hvReq = wrData[BIT_HIGH_VOLTAGE_ENABLE] && !high_voltage_enable;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (ctrlWr) begin
      nxt_ctrl[BIT_MASS] = wrData[BIT_MASS];
      // Both selects at once is refused; a held one blocks the other.
      if (wrData[BIT_PGM] && wrData[BIT_ERASE]) begin
        nxt_ctrl[BIT_PGM] = ctrl_ff[BIT_PGM];
        nxt_ctrl[BIT_ERASE] = ctrl_ff[BIT_ERASE];
      end else begin
        nxt_ctrl[BIT_PGM] = wrData[BIT_PGM] && !eraseSel;
        nxt_ctrl[BIT_ERASE] = wrData[BIT_ERASE] && !program_select;
      end
      if (!wrData[BIT_HIGH_VOLTAGE_ENABLE]) begin
        nxt_ctrl[BIT_HIGH_VOLTAGE_ENABLE] = 1'b0;
      end else if (hvReq) begin
        nxt_ctrl[BIT_HIGH_VOLTAGE_ENABLE] = hvOk;
      end
    end
    if (!nxt_ctrl[BIT_PGM] && !nxt_ctrl[BIT_ERASE]) begin
      nxt_ctrl[BIT_HIGH_VOLTAGE_ENABLE] = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RESET[3:0];
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Tracks select, protect read, latch write, then high voltage.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      seq_ff <= SEQ_IDLE;
      latchAddr_ff <= 16'h0000;
    end else begin
      case (seq_ff)
        SEQ_IDLE: begin
          if (nxt_ctrl[BIT_PGM] || nxt_ctrl[BIT_ERASE]) begin
            seq_ff <= SEQ_SELECTED;
          end
        end
        SEQ_SELECTED: begin
          if (!nxt_ctrl[BIT_PGM] && !nxt_ctrl[BIT_ERASE]) begin
            seq_ff <= SEQ_IDLE;
          end else if (protRd) begin
            seq_ff <= SEQ_PROT_READ;
          end
        end
        SEQ_PROT_READ: begin
          if (!nxt_ctrl[BIT_PGM] && !nxt_ctrl[BIT_ERASE]) begin
            seq_ff <= SEQ_IDLE;
          end else if (wrStb && inArr) begin
            seq_ff <= SEQ_LATCHED;
            latchAddr_ff <= addr;
          end
        end
        SEQ_LATCHED: begin
          if (!nxt_ctrl[BIT_PGM] && !nxt_ctrl[BIT_ERASE]) begin
            seq_ff <= SEQ_IDLE;
          end else if (nxt_ctrl[BIT_HIGH_VOLTAGE_ENABLE]) begin
            seq_ff <= SEQ_HIGH_V;
          end
        end
        SEQ_HIGH_V: begin
          if (!nxt_ctrl[BIT_HIGH_VOLTAGE_ENABLE]) begin
            seq_ff <= SEQ_IDLE;
          end
        end
        default: seq_ff <= SEQ_IDLE;
      endcase
    end
  end

  assign pumpOn = high_voltage_enable;
  assign highVoltage = high_voltage_enable;

  // Array writes only take effect under high voltage in program mode.
  assign arr.wrEn = wrStb && inArr && program_select &&
    high_voltage_enable && seq_ff == SEQ_HIGH_V &&
    (addr >> 6) == (latchAddr_ff >> 6);
  assign arr.wrAddr = arr.wrEn ? addr : latchAddr_ff;
  assign arr.wrData = wrData;
  // Erase fires when erase select drops while high voltage is held.
  assign arr.massErase = ctrlWr && eraseSel && massSel &&
    high_voltage_enable && !wrData[BIT_ERASE];
  assign arr.pageErase = ctrlWr && eraseSel && !massSel &&
    high_voltage_enable && !wrData[BIT_ERASE];
  assign arr.rdEn = rdStb && inArr;
  assign arr.rdAddr = addr;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdArr_ff <= 1'b0;
      rdCtrl_ff <= 1'b0;
      rdData_ff <= 8'h00;
    end else begin
      rdArr_ff <= rdStb && inArr;
      rdCtrl_ff <= rdStb && addr == CTRL_ADDR;
      rdData_ff <= {4'h0, ctrl_ff};
    end
  end

  // Locked parts hide the array except for reads while the sequence sits in SEQ_PROT_READ.
  always_comb begin
    if (rdCtrl_ff) begin
      rdData = rdData_ff;
    end else if (rdArr_ff && (!secureLock || seq_ff == SEQ_PROT_READ)) begin
      rdData = arr.rdData;
    end else if (rdArr_ff) begin
      rdData = 8'h00;
    end else begin
      rdData = 8'h00;
    end
  end

  a_select_excl: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(program_select && eraseSel)) else $error("both selects set");
  a_hv_needs_sel: assert property (@(posedge core_clk) disable iff (!rst_n)
    high_voltage_enable |-> (program_select || eraseSel))
    else $error("high voltage without select");
  a_hv_sequence: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(high_voltage_enable) |-> $past(seq_ff) == SEQ_LATCHED)
    else $error("high voltage skipped sequence");
  a_hv_protect: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(high_voltage_enable) && $past(!massSel) |-> !$past(regionProt))
    else $error("high voltage on protected page");
  a_pump_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    pumpOn == high_voltage_enable && highVoltage == pumpOn)
    else $error("pump not following bit");
  a_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    rdCtrl_ff |-> rdData[7:4] == 4'h0)
    else $error("upper nibble not zero");
  a_reset_clear: assert property (@(posedge core_clk)
    !$past(rst_n) |-> ctrl_ff == 4'h0)
    else $error("control not cleared");
  a_erase_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    arr.massErase |-> massSel && !arr.pageErase)
    else $error("erase mode mismatch");
endmodule : fpec_ctrl
`default_nettype wire

// ==== test/fpec_cpu_model.sv ====
// CPU-side bus model issuing byte reads and writes to the flash block.
`timescale 1ns/100ps
`default_nettype none
module fpec_cpu_model (
  input wire logic core_clk, // System clock.
  input wire logic [7:0] rdData, // Read data from the block.
  output logic [15:0] addr, // Byte address.
  output logic [7:0] wrData, // Write data.
  output logic wrStb, // Write strobe.
  output logic rdStb // Read strobe.
);
  initial begin
    addr = 16'h0000;
    wrData = 8'h00;
    wrStb = 1'b0;
    rdStb = 1'b0;
  end
  // Data are inverted after the strobe so stale bytes are never reused.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge core_clk);
    wrStb <= 1'b0;
    wrData <= ~d;
  endtask : wr
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge core_clk);
    rdStb <= 1'b0;
    #1 d = rdData;
  endtask : rd
endmodule : fpec_cpu_model
`default_nettype wire

// ==== test/fpec_ctrl_tb.sv ====
// Self-checking bench for the flash program and erase control block.
`timescale 1ns/100ps
`default_nettype none
module fpec_ctrl_tb;
  import fpec_pkg::*;
  logic core_clk;
  logic rst_n;
  logic secureLock;
  logic [15:0] addr;
  logic [7:0] wrData;
  logic wrStb;
  logic rdStb;
  logic [7:0] rdData;
  logic pumpOn;
  logic highVoltage;
  logic [7:0] got;
  int n_errors;
  int cmp_count;
  fpec_ctrl i_fpec_ctrl (.core_clk(core_clk), .rst_n(rst_n), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .secureLock(secureLock), .rdData(rdData), .pumpOn(pumpOn),
    .highVoltage(highVoltage));
  fpec_cpu_model i_fpec_cpu_model (.core_clk(core_clk), .rdData(rdData),
    .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_fpec_cpu_model.wr(a, d);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    i_fpec_cpu_model.rd(a, got);
    chk(got, e);
  endtask : rd
  // Waits past the edge so the pump outputs have settled.
  task automatic pump(input logic e);
    #1;
    chk({6'h00, pumpOn, highVoltage}, {6'h00, e, e});
  endtask : pump
  task automatic arm(input logic [7:0] sel, input logic [15:0] a);
    wr(CTRL_ADDR, sel);
    i_fpec_cpu_model.rd(PROT_ADDR, got);
    wr(a, 8'h00);
    wr(CTRL_ADDR, sel | 8'h08);
  endtask : arm
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("mismatch at %0t: run timed out", $time);
    stop_test();
  end
  initial begin
    rst_n = 1'b0;
    secureLock = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(CTRL_ADDR, 8'h00);
    pump(1'b0);
    $display("test reset done");
    wr(CTRL_ADDR, 8'hF3);
    rd(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'hF1);
    rd(CTRL_ADDR, 8'h01);
    wr(CTRL_ADDR, 8'h03);
    rd(CTRL_ADDR, 8'h01);
    wr(CTRL_ADDR, 8'h09);
    rd(CTRL_ADDR, 8'h01);
    pump(1'b0);
    wr(CTRL_ADDR, 8'h00);
    $display("test interlock done");
    // The array wakes blank, and a mass erase comes first.
    arm(8'h06, 16'h9000);
    pump(1'b1);
    wr(CTRL_ADDR, 8'h0C);
    pump(1'b0);
    rd(CTRL_ADDR, 8'h04);
    wr(CTRL_ADDR, 8'h00);
    rd(USER_BASE, 8'hFF);
    rd(USER_TOP, 8'hFF);
    rd(VEC_TOP, 8'hFF);
    rd(PROT_ADDR, 8'hFF);
    $display("test mass erase done");
    arm(8'h01, 16'h9000);
    pump(1'b1);
    wr(16'h9000, 8'h5A);
    wr(CTRL_ADDR, 8'h08);
    pump(1'b0);
    rd(CTRL_ADDR, 8'h00);
    rd(16'h9000, 8'h5A);
    @(posedge core_clk) secureLock <= 1'b1;
    rd(16'h9000, 8'h00);
    @(posedge core_clk) secureLock <= 1'b0;
    $display("test program done");
    arm(8'h01, VEC_BASE);
    pump(1'b0);
    rd(CTRL_ADDR, 8'h01);
    wr(CTRL_ADDR, 8'h00);
    $display("test vector lock done");
    arm(8'h01, PROT_ADDR);
    pump(1'b1);
    wr(PROT_ADDR, 8'h21);
    wr(CTRL_ADDR, 8'h08);
    wr(PROT_ADDR, 8'h00);
    rd(PROT_ADDR, 8'h21);
    arm(8'h01, 16'h9080);
    pump(1'b0);
    wr(CTRL_ADDR, 8'h00);
    arm(8'h01, 16'h907F);
    pump(1'b1);
    wr(CTRL_ADDR, 8'h08);
    $display("test protection done");
    arm(8'h02, 16'h9000);
    pump(1'b1);
    wr(CTRL_ADDR, 8'h08);
    rd(16'h9000, 8'hFF);
    rd(PROT_ADDR, 8'h21);
    $display("test page erase done");
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(PROT_ADDR, 8'h21);
    rd(CTRL_ADDR, 8'h00);
    $display("test second reset done");
    stop_test();
  end
endmodule : fpec_ctrl_tb
`default_nettype wire
